// ---- lpr_pkg.sv ----
// Shared constants for the linear pixel readout sequencer and its controller.
package lpr_pkg;
  localparam int LPR_NUM_PIX = 64;
  localparam int LPR_PIX_W = 8;
  localparam int LPR_END_EDGE = 65;
  localparam int LPR_RESTART_EDGE = 66;
  localparam int LPR_FLUSH_CYCLES = 12;
  localparam int LPR_FLUSH_CYCLES_MAX = 15;
  localparam int LPR_MCLK_PERIOD_NS = 4;
  localparam int LPR_LCLK_PERIOD_NS = 2000;
  localparam int LPR_LCLK_HALF_CYC = LPR_LCLK_PERIOD_NS / (2 * LPR_MCLK_PERIOD_NS);
  localparam int LPR_INTEG_W = 16;
  localparam int LPR_EDGE_CNT_W = 7;
  localparam int LPR_DIV_W = 12;
  localparam int LPR_FLUSH_W = 4;
endpackage

// ---- lpr_link_if.sv ----
// Link between the sensor sequencer and its controller.
`timescale 1ns/1ns
interface lpr_link_if #(parameter int PIX_W = lpr_pkg::LPR_PIX_W);
  logic lclk;
  logic si;
  logic [PIX_W-1:0] ao_data;
  logic ao_oe;
  modport dev (input lclk, input si, output ao_data, output ao_oe);
  modport ctl (output lclk, output si, input ao_data, input ao_oe);
endinterface

// ---- lpr_ctl.sv ----
// Controller end: makes the shift clock, issues start pulses and collects pixels.
`timescale 1ns/1ns
module lpr_ctl #(
  parameter int PIX_W = lpr_pkg::LPR_PIX_W,
  parameter int HALF_CYC = lpr_pkg::LPR_LCLK_HALF_CYC
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Link.
  lpr_link_if.ctl link,
  // User requests.
  input wire logic start_in,
  input wire logic flush_in,
  // User results.
  output logic busy_out,
  output logic flush_busy_out,
  output logic [PIX_W-1:0] pixel_out,
  output logic [lpr_pkg::LPR_EDGE_CNT_W-1:0] pixel_idx_out,
  output logic pixel_valid_out
);
  import lpr_pkg::*;

  typedef enum logic [0:0] {LPR_ST_IDLE, LPR_ST_READ} lpr_ctl_state_e;

  // A half period below two cycles leaves the sensor no room to resolve the clock edges.
  if (HALF_CYC < 2 || HALF_CYC >= (1 << LPR_DIV_W)) begin : g_bad_half_cyc
    $error("HALF_CYC out of range.");
  end

  lpr_ctl_state_e st_r, st_nxt;
  logic [LPR_DIV_W-1:0] div_r, div_nxt;
  logic lclk_r, lclk_nxt;
  logic si_r, si_nxt;
  logic [LPR_EDGE_CNT_W-1:0] edges_r, edges_nxt;
  logic start_req_r, start_req_nxt;
  logic [LPR_FLUSH_W-1:0] flush_cnt_r, flush_cnt_nxt;
  logic oe_s1_r, oe_s2_r;
  logic [PIX_W-1:0] ao_s1_r, ao_s2_r;
  logic busy_nxt, flush_busy_nxt, pix_valid_nxt;
  logic [PIX_W-1:0] pix_nxt;
  logic [LPR_EDGE_CNT_W-1:0] pix_idx_nxt;
  logic toggle, rise, fall, pending;

  always_comb begin
    toggle = (div_r == LPR_DIV_W'(HALF_CYC - 1));
    rise = toggle && !lclk_r;
    fall = toggle && lclk_r;
    pending = start_req_r || (flush_cnt_r != '0);
    div_nxt = toggle ? '0 : div_r + 1'b1;
    // The clock runs free so a started readout always sees all its edges. [RULE_10]
    lclk_nxt = toggle ? !lclk_r : lclk_r;
    st_nxt = st_r;
    edges_nxt = edges_r;
    si_nxt = si_r;
    start_req_nxt = start_req_r || start_in;
    flush_cnt_nxt = flush_cnt_r;
    if (flush_in && flush_cnt_r == '0) begin
      flush_cnt_nxt = LPR_FLUSH_W'(LPR_FLUSH_CYCLES); // [RULE_16]
    end
    pix_nxt = pixel_out;
    pix_idx_nxt = pixel_idx_out;
    pix_valid_nxt = 1'b0;
    if (fall) begin
      // The start pulse changes on the falling edge so it is stable around the rising edge.
      si_nxt = 1'b0; // [RULE_17]
      if (pending && (st_r == LPR_ST_IDLE || edges_r == LPR_EDGE_CNT_W'(LPR_END_EDGE))) begin
        si_nxt = 1'b1; // [RULE_03] [RULE_09]
        if (flush_cnt_r != '0) begin
          flush_cnt_nxt = flush_cnt_r - 1'b1;
        end else begin
          start_req_nxt = start_in;
        end
      end
      if (oe_s2_r) begin
        pix_nxt = ao_s2_r;
        pix_idx_nxt = edges_r - 1'b1;
        pix_valid_nxt = 1'b1;
      end
    end
    if (rise) begin
      if (si_r) begin
        st_nxt = LPR_ST_READ;
        edges_nxt = LPR_EDGE_CNT_W'(1);
      end else if (st_r == LPR_ST_READ) begin
        if (edges_r == LPR_EDGE_CNT_W'(LPR_END_EDGE)) begin
          st_nxt = LPR_ST_IDLE;
        end else begin
          edges_nxt = edges_r + 1'b1;
        end
      end
    end
    busy_nxt = (st_nxt == LPR_ST_READ) && (edges_nxt != LPR_EDGE_CNT_W'(LPR_END_EDGE));
    flush_busy_nxt = (flush_cnt_nxt != '0);
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= LPR_ST_IDLE;
      div_r <= '0;
      lclk_r <= 1'b0;
      si_r <= 1'b0;
      edges_r <= '0;
      start_req_r <= 1'b0;
      flush_cnt_r <= '0;
      oe_s1_r <= 1'b0;
      oe_s2_r <= 1'b0;
      ao_s1_r <= '0;
      ao_s2_r <= '0;
      busy_out <= 1'b0;
      flush_busy_out <= 1'b0;
      pixel_out <= '0;
      pixel_idx_out <= '0;
      pixel_valid_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      lclk_r <= lclk_nxt;
      si_r <= si_nxt;
      edges_r <= edges_nxt;
      start_req_r <= start_req_nxt;
      flush_cnt_r <= flush_cnt_nxt;
      oe_s1_r <= link.ao_oe;
      oe_s2_r <= oe_s1_r;
      ao_s1_r <= link.ao_data;
      ao_s2_r <= ao_s1_r;
      busy_out <= busy_nxt;
      flush_busy_out <= flush_busy_nxt;
      pixel_out <= pix_nxt;
      pixel_idx_out <= pix_idx_nxt;
      pixel_valid_out <= pix_valid_nxt;
    end
  end

  assign link.lclk = lclk_r;
  assign link.si = si_r;
endmodule // lpr_ctl

// ---- lpr_sensor_dev.sv ----
// Sensor end: shift register sequencer, phase generator and gated pixel output.
// Contract
// RULE_01 - One shift stage per pixel sequences transfer.
// RULE_02 - Start pulse enters stage one, shifts on clock.
// RULE_03 - Start high at rising edge begins output.
// RULE_04 - Integration time equals interval between start pulses.
// RULE_05 - First pixel shown after settling, held valid.
// RULE_06 - Each next rising edge shows next pixel.
// RULE_07 - 65th edge ends output, output goes high-impedance. Here the data is driven to zero with the enable low instead.
// RULE_08 - 65th edge clears all stages for restart.
// RULE_09 - Controller may restart at the 66th edge.
// RULE_10 - Controller keeps clock running for 65 edges.
// RULE_11 - Output enabled only during 64 output cycles.
// RULE_12 - Sense node reset every clock cycle.
// RULE_13 - Sample while clock high, hold while low.
// RULE_14 - Phase controls synchronous, derived from shift stages.
// RULE_15 - Pixels transferred singly under clock and start.
// RULE_16 - Controller flushes with 12 to 15 cycles.
// RULE_17 - Start pulse high for exactly one edge.
`timescale 1ns/1ns
module lpr_sensor_dev #(
  parameter int PIX_W = lpr_pkg::LPR_PIX_W,
  parameter int NUM_PIX = lpr_pkg::LPR_NUM_PIX
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Link.
  lpr_link_if.dev link,
  // Pixel source.
  input wire logic [PIX_W-1:0] pixel_value_in,
  output logic [$clog2(NUM_PIX)-1:0] pixel_index_out,
  // Phase generator view.
  output logic sense_reset_out,
  output logic sample_out,
  output logic transfer_out,
  // Integration status.
  output logic start_seen_out,
  output logic [lpr_pkg::LPR_INTEG_W-1:0] integ_edges_out
);
  import lpr_pkg::*;

  localparam int IDX_W = $clog2(NUM_PIX);

  if (NUM_PIX < 2 || PIX_W < 1) begin : g_bad_size
    $error("NUM_PIX or PIX_W out of range.");
  end

  // Position of the single token; the lowest set stage wins if several entered.
  function automatic logic [IDX_W-1:0] token_index(input logic [NUM_PIX-1:0] stages);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = NUM_PIX - 1; i >= 0; i--) begin
      if (stages[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  // Link pins come from another party and pass two flops first.
  logic lclk_s1_r, lclk_s2_r, lclk_s3_r;
  logic si_s1_r, si_s2_r;
  logic rise;

  logic [NUM_PIX-1:0] shift_r, shift_nxt;
  logic oe_r, oe_nxt;
  logic [PIX_W-1:0] ao_r, ao_nxt;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic sense_reset_nxt, sample_nxt, transfer_nxt;
  logic start_seen_nxt;
  logic [LPR_INTEG_W-1:0] integ_cnt_r, integ_cnt_nxt;
  logic [LPR_INTEG_W-1:0] integ_edges_nxt;
  logic accept;

  always_comb begin
    rise = lclk_s2_r && !lclk_s3_r;
    shift_nxt = shift_r;
    accept = 1'b0;
    if (rise) begin
      if (shift_r[NUM_PIX-1]) begin
        // The edge after the last pixel empties the register and refuses a start.
        shift_nxt = '0; // [RULE_07] [RULE_08]
      end else begin
        shift_nxt = {shift_r[NUM_PIX-2:0], si_s2_r}; // [RULE_01] [RULE_02] [RULE_06]
        accept = si_s2_r; // [RULE_03]
      end
    end
    // Enable follows the shift stages, so it covers exactly the output cycles.
    oe_nxt = |shift_nxt; // [RULE_11]
    idx_nxt = token_index(shift_nxt); // [RULE_06] [RULE_15]
    // Track while the link clock is high, hold while it is low. [RULE_13]
    ao_nxt = ao_r;
    if (!oe_nxt) begin
      ao_nxt = '0; // [RULE_07]
    end else if (lclk_s2_r) begin
      ao_nxt = pixel_value_in; // [RULE_05]
    end
    sense_reset_nxt = rise; // [RULE_12]
    sample_nxt = lclk_s2_r && (|shift_r); // [RULE_13] [RULE_14]
    transfer_nxt = rise && (|shift_nxt); // [RULE_14] [RULE_15]
    integ_cnt_nxt = integ_cnt_r;
    integ_edges_nxt = integ_edges_out;
    start_seen_nxt = 1'b0;
    if (rise) begin
      if (accept) begin
        integ_edges_nxt = integ_cnt_r + 1'b1; // [RULE_04]
        integ_cnt_nxt = '0;
        start_seen_nxt = 1'b1;
      end else if (integ_cnt_r != '1) begin
        integ_cnt_nxt = integ_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lclk_s1_r <= 1'b0;
      lclk_s2_r <= 1'b0;
      lclk_s3_r <= 1'b0;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
      shift_r <= '0;
      oe_r <= 1'b0;
      ao_r <= '0;
      idx_r <= '0;
      sense_reset_out <= 1'b0;
      sample_out <= 1'b0;
      transfer_out <= 1'b0;
      start_seen_out <= 1'b0;
      integ_cnt_r <= '0;
      integ_edges_out <= '0;
    end else begin
      lclk_s1_r <= link.lclk;
      lclk_s2_r <= lclk_s1_r;
      lclk_s3_r <= lclk_s2_r;
      si_s1_r <= link.si;
      si_s2_r <= si_s1_r;
      shift_r <= shift_nxt;
      oe_r <= oe_nxt;
      ao_r <= ao_nxt;
      idx_r <= idx_nxt;
      sense_reset_out <= sense_reset_nxt;
      sample_out <= sample_nxt;
      transfer_out <= transfer_nxt;
      start_seen_out <= start_seen_nxt;
      integ_cnt_r <= integ_cnt_nxt;
      integ_edges_out <= integ_edges_nxt;
    end
  end

  // Data reads as zero while the enable is low; the shared wire is resolved outside.
  assign link.ao_data = ao_r;
  assign link.ao_oe = oe_r;
  assign pixel_index_out = idx_r;
endmodule // lpr_sensor_dev

// ---- lpr_chk.sv ----
// Assertion checker for the link between sensor and controller.
`timescale 1ns/1ns
module lpr_chk #(parameter int HALF_CYC = 8) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Link.
  input wire logic lclk,
  input wire logic si,
  input wire logic [7:0] ao_data,
  input wire logic ao_oe
);
  logic lclk_d_r;
  logic [6:0] oe_rises_r;
  logic [1:0] si_rises_r;
  // Rises are seen one cycle late, which the bounds below allow for.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lclk_d_r <= 1'b0;
      oe_rises_r <= 7'h00;
      si_rises_r <= 2'h0;
    end else begin
      lclk_d_r <= lclk;
      oe_rises_r <= !ao_oe ? 7'h00 : oe_rises_r + 7'(lclk && !lclk_d_r);
      si_rises_r <= !si ? 2'h0 : si_rises_r + 2'(lclk && !lclk_d_r);
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  chk_oe_rise_edge: assert property ($rose(ao_oe) |-> $past(lclk, 2) && !$past(lclk, HALF_CYC))
    else $error("output enable rose away from a shift clock rise");
  chk_oe_needs_start: assert property ($rose(ao_oe) |-> $past(si, 2))
    else $error("output enable rose without a start pulse");
  chk_oe_fall_edge: assert property ($fell(ao_oe) |-> $past(lclk, 2) && !$past(lclk, HALF_CYC))
    else $error("output enable fell away from a shift clock rise");
  chk_idle_out_zero: assert property (!ao_oe |-> ao_data == 8'h00)
    else $error("pixel output not released while disabled");
  chk_output_length: assert property ($fell(ao_oe) |-> oe_rises_r == 7'd64)
    else $error("output period not 64 shift clocks");
  chk_hold_while_low: assert property (!lclk && !$past(lclk, HALF_CYC - 2) |-> $stable(ao_data))
    else $error("pixel output moved while shift clock low");
  chk_restart_spacing: assert property ($rose(ao_oe) |-> !$past(ao_oe, 2 * HALF_CYC - 1))
    else $error("output period restarted too early");
  chk_start_one_rise: assert property ($fell(si) |-> si_rises_r == 2'd1)
    else $error("start pulse not high over exactly one rise");
  chk_start_at_fall: assert property ($rose(si) |-> !lclk)
    else $error("start pulse raised while shift clock high");
  cov_frame_start: cover property ($rose(ao_oe));
  cov_frame_end: cover property ($fell(ao_oe));
  cov_back_to_back: cover property ($rose(ao_oe) && $past(ao_oe, 2 * HALF_CYC + 1));
endmodule // lpr_chk

// ---- tb.sv ----
// Testbench joining sensor and controller ends.
`timescale 1ns/1ns
module tb;
  import lpr_pkg::*;
  localparam int HC = 8;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic start_in = 1'b0;
  logic flush_in = 1'b0;
  logic [7:0] pix_val = 8'h00;
  logic [7:0] pat = 8'h00;
  logic lclk_d = 1'b0;
  logic oe_d = 1'b0;
  logic busy, fbusy, pvalid, srst, xfer;
  logic [7:0] pix;
  logic [6:0] pidx;
  logic [5:0] sidx;
  logic [15:0] integ;
  int num_errors = 0;
  int num_checks = 0;
  logic seen;
  int n_frm = 0, n_rise = 0, n_rst = 0, n_xfer = 0, t_fall = 0, gap = 0, cyc = 0, n_seen = 0;
  lpr_link_if u_link();
  lpr_sensor_dev u_lpr_sensor_dev (.mclk_in(mclk_in), .resetn_in(resetn_in), .link(u_link.dev),
    .pixel_value_in(pix_val), .pixel_index_out(sidx), .sense_reset_out(srst), .sample_out(),
    .transfer_out(xfer), .start_seen_out(seen), .integ_edges_out(integ));
  lpr_ctl #(.HALF_CYC(HC)) u_lpr_ctl (.mclk_in(mclk_in), .resetn_in(resetn_in), .link(u_link.ctl),
    .start_in(start_in), .flush_in(flush_in), .busy_out(busy), .flush_busy_out(fbusy), .pixel_out(pix),
    .pixel_idx_out(pidx), .pixel_valid_out(pvalid));
  lpr_chk #(.HALF_CYC(HC)) u_lpr_chk (.mclk_in(mclk_in), .resetn_in(resetn_in), .lclk(u_link.lclk),
    .si(u_link.si), .ao_data(u_link.ao_data), .ao_oe(u_link.ao_oe));
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  // Pixel k reads as a pattern of its own index, so order slips show.
  always @(posedge mclk_in) begin
    pix_val <= {2'b10, sidx} ^ pat;
    cyc <= cyc + 1;
    lclk_d <= u_link.lclk;
    oe_d <= u_link.ao_oe;
    if (u_link.lclk && !lclk_d) n_rise <= n_rise + 1;
    if (srst) n_rst <= n_rst + 1;
    if (xfer) n_xfer <= n_xfer + 1;
    if (seen) n_seen <= n_seen + 1;
    if (u_link.ao_oe && !oe_d) begin
      n_frm <= n_frm + 1;
      gap <= cyc - t_fall;
    end
    if (!u_link.ao_oe && oe_d) t_fall <= cyc;
  end
  task check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Busy flags drop briefly between back-to-back readouts, so idle must last a full clock period.
  task wait_busy(input logic v);
    int n;
    int run;
    n = 0;
    run = 0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
      if ((busy | fbusy | u_link.si | u_link.ao_oe) === v) run++;
      else run = 0;
    end while (run < (v ? 1 : 2 * HC) && n < 20000);
  endtask
  task pulse(input bit f);
    @(posedge mclk_in);
    if (f) flush_in <= 1'b1;
    else start_in <= 1'b1;
    @(posedge mclk_in);
    flush_in <= 1'b0;
    start_in <= 1'b0;
  endtask
  task collect(input logic [7:0] p);
    for (int k = 0; k < 64; k++) begin
      int n;
      n = 0;
      do begin
        @(posedge mclk_in);
        #1;
        n++;
      end while (pvalid !== 1'b1 && n < 2000);
      check(16'(pix), 16'({2'b10, 6'(k)} ^ p));
      check(16'(pidx), 16'(k));
    end
  endtask
  initial begin
    repeat (10) @(posedge mclk_in);
    resetn_in <= 1'b1;
    pulse(1'b1);
    wait_busy(1'b0);
    check(16'(n_frm), 16'(LPR_FLUSH_CYCLES));
    pat <= 8'h3c;
    pulse(1'b0);
    collect(8'h3c);
    wait_busy(1'b0);
    check(16'(n_xfer), 16'(13 * LPR_NUM_PIX));
    check(16'(u_link.ao_oe), 16'h0000);
    // A second request during readout must restart at the 66th rise.
    pat <= 8'hc5;
    pulse(1'b0);
    wait_busy(1'b1);
    pulse(1'b0);
    collect(8'hc5);
    collect(8'hc5);
    check(16'(gap), 16'(2 * HC));
    check(integ, 16'(LPR_RESTART_EDGE - 1));
    wait_busy(1'b0);
    @(negedge u_link.lclk);
    repeat (2) @(posedge mclk_in);
    #1;
    check(16'(n_rst), 16'(n_rise));
    check(16'(n_rise >= 15 * LPR_END_EDGE), 16'h0001);
    check(16'(n_seen), 16'h000f);
    check(16'(n_frm), 16'h000f);
    close_out;
  end
  initial begin
    repeat (40000) @(posedge mclk_in);
    num_errors++;
    close_out;
  end
endmodule // tb
